// ===== src/qb_ports.sv
// Ports 4, 5 and 6 with quasi-bidirectional pins and alternate functions.
// Function
// - Port 4 pins selectable per configuration register
// - Reset, access low: pins 3..1 chip enables high
// - Reset, access low: pins 7..4, 0 driven low
// - Port 4 carries chip enables 0-3, address 16-19
// - Port 5 resets to weak-pullup ones
// - A pin at one acts as input
// - Writing zero holds strong pulldown until one
// - Zero-to-one write gives brief strong high
// - Port 5: CAN transmit, receive, timer input
// - Port 5 pins 4-7 peripheral chip enables
// - Port 6 resets to ones, multiple roles
// - Port 6 pin 0 chip enable four
// - Port 6: enable seven, address 20-21, serial
module qb_ports #(
	parameter int W = qb_ports_pkg::PORT_WIDTH
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         external_access_select,
	input  wire logic         cfg_wr,
	input  wire logic [W-1:0] cfg_wdata,
	input  wire logic [2:0]   port_wr,
	input  wire logic [W-1:0] port_wdata,
	input  wire logic [W-1:0] p5_alt_en,
	input  wire logic [W-1:0] p6_alt_en,
	input  wire logic [3:0]   program_chip_select_low,
	input  wire logic [3:0]   upper_address_low,
	input  wire logic [1:0]   upper_address_high,
	input  wire logic         program_chip_select_four,
	input  wire logic         program_chip_select_seven,
	input  wire logic [3:0]   peripheral_select,
	input  wire logic         can_transmit_out,
	input  wire logic         third_serial_transmit,
	input  wire logic [W-1:0] p4_in,
	input  wire logic [W-1:0] p5_in,
	input  wire logic [W-1:0] p6_in,
	output logic [W-1:0]      memory_port_config_register,
	output logic [W-1:0]      p4_out,
	output logic [W-1:0]      p4_oe,
	output logic [W-1:0]      p5_out,
	output logic [W-1:0]      p5_oe,
	output logic [W-1:0]      p5_pullup,
	output logic [W-1:0]      p6_out,
	output logic [W-1:0]      p6_oe,
	output logic [W-1:0]      p6_pullup,
	output logic [W-1:0]      p4_read,
	output logic [W-1:0]      p5_read,
	output logic [W-1:0]      p6_read,
	output logic              can_receive_in,
	output logic              third_timer_input,
	output logic              third_serial_receive
);
	logic [W-1:0] cfg_reg;
	logic [W-1:0] p4_cfg_en;
	logic [W-1:0] p4_alt_val;
	logic [W-1:0] p5_alt_val;
	logic [W-1:0] p6_alt_val;

	logic         p4_wr;
	logic         p5_wr;
	logic         p6_wr;

	logic [W-1:0] p4_rd;
	logic [W-1:0] p5_rd;
	logic [W-1:0] p6_rd;

	logic [W-1:0] p4_read_reg;
	logic [W-1:0] p5_read_reg;
	logic [W-1:0] p6_read_reg;

	// Port 4 configuration register; reset clears it, so with access high every pin is plain I/O.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_reg <= qb_ports_pkg::P4_CFG_RESET_EA1;
		end else if (cfg_wr) begin
			cfg_reg <= cfg_wdata;
		end
	end

	// Each strobe bit writes the latch of its own port.
	always_comb begin
		p4_wr = port_wr[0];
		p5_wr = port_wr[1];
		p6_wr = port_wr[2];
	end

	// With access low, every port 4 pin is forced to its memory role.
	always_comb begin
		if (external_access_select) begin
			p4_cfg_en = cfg_reg;
		end else begin
			p4_cfg_en = cfg_reg | qb_ports_pkg::P4_CFG_RESET_EA0;
		end
	end

	// Port 4 memory roles: chip enables low, upper address high.
	always_comb begin
		p4_alt_val = '0;
		p4_alt_val[qb_ports_pkg::P4_CE_LSB +: 4]   = program_chip_select_low;
		p4_alt_val[qb_ports_pkg::P4_ADDR_LSB +: 4] = upper_address_low;
	end

	// Port 5 roles; input-only pins keep a released high level.
	always_comb begin
		p5_alt_val = '1;
		p5_alt_val[qb_ports_pkg::P5_CAN_TX_BIT]  = can_transmit_out;
		p5_alt_val[qb_ports_pkg::P5_CAN_RX_BIT]  = 1'b1;
		p5_alt_val[qb_ports_pkg::P5_TIMER_BIT]   = 1'b1;
		p5_alt_val[qb_ports_pkg::P5_PCE_LSB +: 4] = peripheral_select;
	end

	// Port 6 roles; the serial receive pin stays released high.
	always_comb begin
		p6_alt_val = '1;
		p6_alt_val[qb_ports_pkg::P6_CE4_BIT]       = program_chip_select_four;
		p6_alt_val[qb_ports_pkg::P6_CE7_BIT]       = program_chip_select_seven;
		p6_alt_val[qb_ports_pkg::P6_ADDR_LSB +: 2] = upper_address_high;
		p6_alt_val[qb_ports_pkg::P6_SER_RX_BIT]    = 1'b1;
		p6_alt_val[qb_ports_pkg::P6_SER_TX_BIT]    = third_serial_transmit;
	end

	// Port 4 pins; an enabled role overrides the latch.
	genvar i4;
	generate
		for (i4 = 0; i4 < W; i4++) begin : g_p4
			qb_pin u_pin (
				.core_clk    (core_clk),
				.rst         (rst),
				.wr_en       (p4_wr),
				.wr_bit      (port_wdata[i4]),
				.alt_en      (p4_cfg_en[i4]),
				.alt_out     (p4_alt_val[i4]),
				.pin_in      (p4_in[i4]),
				.latch       (),
				.pin_out     (p4_out[i4]),
				.pin_oe      (p4_oe[i4]),
				.weak_pullup (),
				.read_bit    (p4_rd[i4])
			);
		end
	endgenerate

	// Port 5 pins with quasi-bidirectional drive.
	genvar i5;
	generate
		for (i5 = 0; i5 < W; i5++) begin : g_p5
			qb_pin u_pin (
				.core_clk    (core_clk),
				.rst         (rst),
				.wr_en       (p5_wr),
				.wr_bit      (port_wdata[i5]),
				.alt_en      (p5_alt_en[i5]),
				.alt_out     (p5_alt_val[i5]),
				.pin_in      (p5_in[i5]),
				.latch       (),
				.pin_out     (p5_out[i5]),
				.pin_oe      (p5_oe[i5]),
				.weak_pullup (p5_pullup[i5]),
				.read_bit    (p5_rd[i5])
			);
		end
	endgenerate

	// Port 6 pins with quasi-bidirectional drive.
	genvar i6;
	generate
		for (i6 = 0; i6 < W; i6++) begin : g_p6
			qb_pin u_pin (
				.core_clk    (core_clk),
				.rst         (rst),
				.wr_en       (p6_wr),
				.wr_bit      (port_wdata[i6]),
				.alt_en      (p6_alt_en[i6]),
				.alt_out     (p6_alt_val[i6]),
				.pin_in      (p6_in[i6]),
				.latch       (),
				.pin_out     (p6_out[i6]),
				.pin_oe      (p6_oe[i6]),
				.weak_pullup (p6_pullup[i6]),
				.read_bit    (p6_rd[i6])
			);
		end
	endgenerate

	// Port 4 pin levels are registered once for reads.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			p4_read_reg <= qb_ports_pkg::LATCH_RESET;
		end else begin
			p4_read_reg <= p4_rd;
		end
	end

	// Port 5 pin levels feed reads and the alternate inputs.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			p5_read_reg <= qb_ports_pkg::LATCH_RESET;
		end else begin
			p5_read_reg <= p5_rd;
		end
	end

	// Port 6 pin levels feed reads and the serial receive input.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			p6_read_reg <= qb_ports_pkg::LATCH_RESET;
		end else begin
			p6_read_reg <= p6_rd;
		end
	end

	// Registered values leave the block here.
	assign memory_port_config_register = cfg_reg;
	assign p4_read              = p4_read_reg;
	assign p5_read              = p5_read_reg;
	assign p6_read              = p6_read_reg;
	assign can_receive_in       = p5_read_reg[qb_ports_pkg::P5_CAN_RX_BIT];
	assign third_timer_input    = p5_read_reg[qb_ports_pkg::P5_TIMER_BIT];
	assign third_serial_receive = p6_read_reg[qb_ports_pkg::P6_SER_RX_BIT];
endmodule

// ===== src/qb_ports_pkg.sv
// Constants shared by the quasi-bidirectional port block.
package qb_ports_pkg;
	localparam int          PORT_WIDTH         = 8;
	localparam int          STRONG_HIGH_CYCLES = 2;
	localparam logic [7:0]  LATCH_RESET        = 8'hFF;
	localparam logic [7:0]  P4_CFG_RESET_EA0   = 8'hFF;
	localparam logic [7:0]  P4_CFG_RESET_EA1   = 8'h00;
	localparam logic [7:0]  P4_OUT_RESET_EA0   = 8'h0E;
	localparam int          P4_CE_LSB          = 0;
	localparam int          P4_ADDR_LSB        = 4;
	localparam int          P5_CAN_TX_BIT      = 0;
	localparam int          P5_CAN_RX_BIT      = 1;
	localparam int          P5_TIMER_BIT       = 2;
	localparam int          P5_PCE_LSB         = 4;
	localparam int          P6_CE4_BIT         = 0;
	localparam int          P6_CE7_BIT         = 3;
	localparam int          P6_ADDR_LSB        = 4;
	localparam int          P6_SER_RX_BIT      = 6;
	localparam int          P6_SER_TX_BIT      = 7;
endpackage

// ===== src/qb_pin.sv
// One quasi-bidirectional pin: latch, strong pulldown, brief strong pull-up.
module qb_pin #(
	parameter int STRONG_CYCLES = qb_ports_pkg::STRONG_HIGH_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic wr_en,
	input  wire logic wr_bit,
	input  wire logic alt_en,
	input  wire logic alt_out,
	input  wire logic pin_in,
	output logic      latch,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      weak_pullup,
	output logic      read_bit
);
	logic       latch_reg;
	logic       drive_val;
	logic       prev_val_reg;
	logic [3:0] kick_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			latch_reg <= 1'b1;
		end else if (wr_en) begin
			latch_reg <= wr_bit;
		end
	end

	assign drive_val = alt_en ? alt_out : latch_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_val_reg <= 1'b1;
		end else begin
			prev_val_reg <= drive_val;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			kick_reg <= 4'h0;
		end else if (drive_val && !prev_val_reg) begin
			kick_reg <= 4'(STRONG_CYCLES - 1);
		end else if (!drive_val) begin
			kick_reg <= 4'h0;
		end else if (kick_reg != 4'h0) begin
			kick_reg <= kick_reg - 4'h1;
		end
	end

	assign latch       = latch_reg;
	// The strong high starts in the cycle of the rise, then the counter holds it one cycle more.
	assign pin_oe      = !drive_val || !prev_val_reg || (kick_reg != 4'h0);
	assign pin_out     = drive_val;
	assign weak_pullup = drive_val;
	assign read_bit    = pin_in;
endmodule

// ===== bench/qb_ports_props.sv
// Checker for the quasi-bidirectional port block.
module qb_ports_props #(
	parameter int W = 8
) (
	input wire logic         core_clk, rst, external_access_select, cfg_wr,
	input wire logic [W-1:0] cfg_wdata, port_wdata, p5_alt_en, p6_alt_en, p5_in,
	input wire logic [W-1:0] memory_port_config_register, p4_out, p5_out, p5_oe,
	input wire logic [W-1:0] p5_pullup, p6_out, p6_oe, p5_read,
	input wire logic [3:0]   program_chip_select_low, upper_address_low, peripheral_select,
	input wire logic [2:0]   port_wr,
	input wire logic [1:0]   upper_address_high,
	input wire logic         program_chip_select_four, program_chip_select_seven,
	input wire logic         can_transmit_out, third_serial_transmit, can_receive_in
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_p4_route: assert property (!external_access_select |->
		p4_out == {upper_address_low, program_chip_select_low}) else $error("p4 route");
	a_p5_alt: assert property (p5_alt_en == 8'hF1 |-> p5_out[0] == can_transmit_out
		&& p5_out[7:4] == peripheral_select) else $error("p5 alternate");
	a_p6_alt: assert property (p6_alt_en == 8'hFF |-> p6_out[0] == program_chip_select_four
		&& p6_out[3] == program_chip_select_seven && p6_out[5:4] == upper_address_high
		&& p6_out[7] == third_serial_transmit) else $error("p6 alternate");
	a_read_lag: assert property (!$past(rst) |-> p5_read == $past(p5_in)
		&& can_receive_in == $past(p5_in[1])) else $error("read lag");
	a_pull_down: assert property (port_wr[1] && !port_wdata[3] && !p5_alt_en[3] |=>
		p5_oe[3] && !p5_out[3]) else $error("pulldown");
	a_kick_len: assert property (port_wr[1] && port_wdata[3] && p5_oe[3] && !p5_out[3]
		&& !p5_alt_en[3] |=> (p5_oe[3] && p5_out[3])[*2] ##1 !p5_oe[3]) else $error("kick");
	a_reset_ones: assert property (disable iff (1'b0) rst && p5_alt_en == '0 && p6_alt_en == '0
		|=> p5_oe == '0 && p6_oe == '0 && p5_pullup == '1) else $error("reset state");
	a_cfg_write: assert property (external_access_select && cfg_wr |=>
		memory_port_config_register == $past(cfg_wdata)) else $error("config write");
	c_kick: cover property (port_wr[1] && port_wdata == 8'hFF);
	c_alt: cover property (p5_alt_en == 8'hF1);
	c_cfg: cover property (cfg_wr);
endmodule
bind qb_ports qb_ports_props #(.W(W)) i_props (.*);

// ===== bench/pin_model.sv
// Pad model: device strong drive wins, an external driver beats the pullup.
module pin_model (
	input  wire logic [7:0] oe, drv, pu, ext_en, ext_val,
	output logic      [7:0] pad
);
	assign pad = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
endmodule

// ===== bench/tb_top.sv
// Testbench for the quasi-bidirectional port block.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk = 0, rst = 1, external_access_select = 0, cfg_wr = 0;
	logic       program_chip_select_four = 0, program_chip_select_seven = 1;
	logic       can_transmit_out = 0, third_serial_transmit = 1;
	logic [7:0] cfg_wdata = '0, port_wdata = '0, p5_alt_en = '0, p6_alt_en = '0;
	logic [7:0] p4_in, p5_in, p6_in, e5 = '0, v5 = '0, e6 = '0, v6 = '0;
	logic [2:0] port_wr = '0;
	logic [3:0] program_chip_select_low = 4'hE, upper_address_low = '0, peripheral_select = '0;
	logic [1:0] upper_address_high = '0;
	logic [7:0] memory_port_config_register, p4_out, p4_oe, p5_out, p5_oe, p5_pullup;
	logic [7:0] p6_out, p6_oe, p6_pullup, p4_read, p5_read, p6_read;
	logic       can_receive_in, third_timer_input, third_serial_receive;
	int         errors = 0, checks = 0;
	qb_ports i_dut (.*);
	pin_model i_p4 (.oe(p4_oe), .drv(p4_out), .pu(8'hFF), .ext_en(8'h00), .ext_val(8'h00),
		.pad(p4_in));
	pin_model i_p5 (.oe(p5_oe), .drv(p5_out), .pu(p5_pullup), .ext_en(e5), .ext_val(v5), .pad(p5_in));
	pin_model i_p6 (.oe(p6_oe), .drv(p6_out), .pu(p6_pullup), .ext_en(e6), .ext_val(v6), .pad(p6_in));
	always #5 core_clk = ~core_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		port_wr = sel;
		port_wdata = d;
		cyc(1);
		port_wr = '0;
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_reset;
		cyc(1);
		chk("p4_out", p4_out, 8'h0E);
		chk("p5_oe", p5_oe, 8'h00);
		chk("p4_oe", p4_oe, 8'hF1);
		chk("p6_read", p6_read, 8'hFF);
		upper_address_low = 4'hA;
		#1 chk("p4_out", p4_out, 8'hAE);
		$display("t_reset done");
	endtask
	task automatic t_quasi;
		wr(3'h6, 8'h00);
		cyc(3);
		chk("p5_out", p5_out, 8'h00);
		chk("p6_oe", p6_oe, 8'hFF);
		chk("p5_pullup", p5_pullup, 8'h00);
		chk("p6_pullup", p6_pullup, 8'h00);
		wr(3'h6, 8'hFF);
		chk("p5_oe", p5_oe, 8'hFF);
		chk("p6_out", p6_out, 8'hFF);
		cyc(2);
		chk("p5_oe", p5_oe, 8'h00);
		e5 = 8'h08;
		cyc(2);
		chk("p5_read", p5_read, 8'hF7);
		chk("timer", third_timer_input, 8'h01);
		e5 = '0;
		$display("t_quasi done");
	endtask
	task automatic t_alt;
		p5_alt_en = 8'hF1;
		p6_alt_en = 8'hFF;
		{can_transmit_out, peripheral_select, program_chip_select_four} = 6'h35;
		{program_chip_select_seven, upper_address_high, third_serial_transmit} = 4'h2;
		e5 = 8'h02;
		e6 = 8'h40;
		wr(3'h2, 8'hFE);
		cyc(2);
		chk("p5_out", p5_out & 8'hF1, 8'hA1);
		chk("p6_out", p6_out & 8'hB9, 8'h11);
		chk("rx", {can_receive_in, third_serial_receive}, 8'h00);
		{p5_alt_en, p6_alt_en, e5, e6} = '0;
		wr(3'h2, 8'hFF);
		$display("t_alt done");
	endtask
	task automatic t_cfg;
		external_access_select = 1;
		program_chip_select_low = 4'h0;
		cfg_wdata = 8'h01;
		cfg_wr = 1;
		cyc(1);
		cfg_wr = 0;
		chk("cfg", memory_port_config_register, 8'h01);
		chk("p4_out", p4_out, 8'hFE);
		cyc(1);
		chk("p4_read", p4_read, 8'hFE);
		$display("t_cfg done");
	endtask
	initial begin
		cyc(3);
		rst = 0;
		t_reset();
		t_quasi();
		t_alt();
		t_cfg();
		wrap_up();
	end
	initial begin
		#100000;
		errors++;
		wrap_up();
	end
endmodule
